//--- verilog/mfio_ports.sv
// four-plus-one parallel i/o ports with latches, pin reads and driver control
`default_nettype none
module mfio_ports #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  resetn_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [7:0]            wr_data_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output var  logic [7:0]            rd_data_o,
  input  wire logic                  pin_output_enable_i,
  input  wire logic                  stop_mode_i,
  input  wire logic                  dual_clock_mode_i,
  input  wire logic [7:0]            p1_func_out_i,
  input  wire logic [7:0]            p4_func_out_i,
  input  wire logic [mfio_pkg::P5_W-1:0] p5_func_out_i,
  input  wire logic [7:0]            p1_in_i,
  input  wire logic [mfio_pkg::P2_W-1:0] p2_in_i,
  input  wire logic [7:0]            p3_in_i,
  input  wire logic [7:0]            p4_in_i,
  input  wire logic [mfio_pkg::P5_W-1:0] p5_in_i,
  output var  mfio_pkg::mfio_pin8_type p1_pins_o,
  output var  mfio_pkg::mfio_pin3_type p2_pins_o,
  output var  mfio_pkg::mfio_pin8_type p3_pins_o,
  output var  mfio_pkg::mfio_pin8_type p4_pins_o,
  output var  mfio_pkg::mfio_pin5_type p5_pins_o,
  output var  logic                  ext_int_o
);
  import mfio_pkg::*;

  // elaboration guard: the register map decodes eight-bit offsets
  if (ADDR_W != mfio_pkg::ADDR_W)
  begin
    $error("mfio_ports: ADDR_W must match the register map width");
  end

  logic [7:0]      p1_latch_r;
  logic [7:0]      p1_dir_r;
  logic [P2_W-1:0] p2_latch_r;
  logic [7:0]      p3_latch_r;
  logic [7:0]      p4_latch_r;
  logic [7:0]      p4_drv_r;
  logic [P5_W-1:0] p5_latch_r;
  logic            p2_in0_d_r;

  // address decode
  wire sel_p1_latch = (addr_i == OFF_P1_LATCH);
  wire sel_p1_dir   = (addr_i == OFF_P1_DIR);
  wire sel_p2_latch = (addr_i == OFF_P2_LATCH);
  wire sel_p2_pin   = (addr_i == OFF_P2_PIN);
  wire sel_p3_latch = (addr_i == OFF_P3_LATCH);
  wire sel_p3_pin   = (addr_i == OFF_P3_PIN);
  wire sel_p4_latch = (addr_i == OFF_P4_LATCH);
  wire sel_p4_drv   = (addr_i == OFF_P4_DRV);
  wire sel_p4_pin   = (addr_i == OFF_P4_PIN);
  wire sel_p5_latch = (addr_i == OFF_P5_LATCH);
  wire sel_p5_pin   = (addr_i == OFF_P5_PIN);

  // register writes
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      p1_latch_r <= RST_P1_LATCH;
      p1_dir_r   <= RST_P1_DIR;
      p2_latch_r <= RST_P2_LATCH;
      p3_latch_r <= RST_P3_LATCH;
      p4_latch_r <= RST_P4_LATCH;
      p4_drv_r   <= RST_P4_DRV;
      p5_latch_r <= RST_P5_LATCH;
    end
    else if (wr_i)
    begin
      if (sel_p1_latch) p1_latch_r <= wr_data_i;
      if (sel_p1_dir)   p1_dir_r   <= wr_data_i;
      if (sel_p2_latch) p2_latch_r <= wr_data_i[P2_W-1:0];
      if (sel_p3_latch) p3_latch_r <= wr_data_i;
      if (sel_p4_latch) p4_latch_r <= wr_data_i;
      if (sel_p4_drv)   p4_drv_r   <= wr_data_i;
      if (sel_p5_latch) p5_latch_r <= wr_data_i[P5_W-1:0];
    end
  end

  // read selection; input-mode bits return the pin, so a
  // read-modify-write copies pin levels into their latches
  wire [7:0] p1_rd = (p1_dir_r & p1_latch_r) | (~p1_dir_r & p1_in_i);
  wire [7:0] rd_nxt =
      sel_p1_latch ? p1_rd :
      sel_p1_dir   ? p1_dir_r :
      sel_p2_latch ? {5'h00, p2_latch_r} :
      sel_p2_pin   ? {5'h00, p2_in_i} :
      sel_p3_latch ? p3_latch_r :
      sel_p3_pin   ? p3_in_i :
      sel_p4_latch ? p4_latch_r :
      sel_p4_drv   ? p4_drv_r :
      sel_p4_pin   ? p4_in_i :
      sel_p5_latch ? {3'h0, p5_latch_r} :
      sel_p5_pin   ? {3'h0, p5_in_i} :
      8'h00;

  // pins are sampled in the read cycle, data shown one cycle later
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rd_data_o <= 8'h00;
    else if (rd_i)
      rd_data_o <= rd_nxt;
  end

  // pin drive values
  wire [7:0] oen8 = {8{pin_output_enable_i}};
  wire [7:0] p1_val = p1_latch_r & p1_func_out_i;
  wire [7:0] p1_oe  = p1_dir_r & oen8;
  wire [P2_W-1:0] p2_oe_raw = ~p2_latch_r & oen8[P2_W-1:0];
  wire [P2_W-1:0] p2_oe;
  assign p2_oe[0] = p2_oe_raw[0] & ~stop_mode_i;
  assign p2_oe[2:1] = p2_oe_raw[2:1] & {2{~dual_clock_mode_i}};
  wire [7:0] p3_oe  = ~p3_latch_r & oen8;
  wire [7:0] p4_val = p4_latch_r & p4_func_out_i;
  wire [7:0] p4_oe  = (p4_drv_r | ~p4_val) & oen8;
  wire [P5_W-1:0] p5_val = p5_latch_r & p5_func_out_i;
  wire [P5_W-1:0] p5_oe  = ~p5_val & oen8[P5_W-1:0];

  // outputs move the cycle after the write lands
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      p1_pins_o <= '0;
      p2_pins_o <= '0;
      p3_pins_o <= '0;
      p4_pins_o <= '0;
      p5_pins_o <= '0;
    end
    else
    begin
      p1_pins_o <= '{dout: p1_val, oe: p1_oe};
      p2_pins_o <= '{dout: p2_latch_r, oe: p2_oe};
      p3_pins_o <= '{dout: p3_latch_r, oe: p3_oe};
      p4_pins_o <= '{dout: p4_val, oe: p4_oe};
      p5_pins_o <= '{dout: p5_val, oe: p5_oe};
    end
  end

  // falling edge on port two bit 0, also when it drives itself
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      p2_in0_d_r <= 1'b0; // no edge until the pin has been seen high
      ext_int_o  <= 1'b0;
    end
    else
    begin
      p2_in0_d_r <= p2_in_i[0];
      ext_int_o  <= p2_in0_d_r & ~p2_in_i[0];
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_dir_to_oe;
    wr_i && sel_p1_dir && pin_output_enable_i ##1 pin_output_enable_i
      |=> p1_pins_o.oe == $past(wr_data_i, 2);
  endproperty
  a_dir_to_oe: assert property (p_dir_to_oe)
    else $error("port one enable does not follow direction write");

  property p_p1_read;
    rd_i && sel_p1_latch |=> rd_data_o ==
      (($past(p1_dir_r) & $past(p1_latch_r)) | (~$past(p1_dir_r) & $past(p1_in_i)));
  endproperty
  a_p1_read: assert property (p_p1_read)
    else $error("port one read mixes latch and pin wrongly");

  property p_p2_upper;
    rd_i && (sel_p2_latch || sel_p2_pin) |=> rd_data_o[7:3] == 5'h00;
  endproperty
  a_p2_upper: assert property (p_p2_upper)
    else $error("port two upper read bits not zero");

  property p_crystal;
    dual_clock_mode_i |=> p2_pins_o.oe[2:1] == 2'h0;
  endproperty
  a_crystal: assert property (p_crystal)
    else $error("crystal pins driven in dual-clock mode");

  property p_edge;
    $fell(p2_in_i[0]) |=> ext_int_o ##1 !ext_int_o || $fell(p2_in_i[0]);
  endproperty
  a_edge: assert property (p_edge)
    else $error("falling edge on port two bit 0 missed");

  property p_stop;
    stop_mode_i |=> !p2_pins_o.oe[0];
  endproperty
  a_stop: assert property (p_stop)
    else $error("port two bit 0 driven in stop mode");

  property p_p3_pin;
    rd_i && sel_p3_pin |=> rd_data_o == $past(p3_in_i);
  endproperty
  a_p3_pin: assert property (p_p3_pin)
    else $error("port three pin read wrong");

  property p_open_drain;
    (p4_pins_o.oe & ~$past(p4_drv_r) & p4_pins_o.dout) == 8'h00;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain bit drives high");

  property p_p4_reads;
    rd_i && (sel_p4_latch || sel_p4_pin) |=> rd_data_o ==
      ($past(sel_p4_pin) ? $past(p4_in_i) : $past(p4_latch_r));
  endproperty
  a_p4_reads: assert property (p_p4_reads)
    else $error("port four read returns wrong source");

  property p_p5_write;
    wr_i && sel_p5_latch |=> p5_latch_r == $past(wr_data_i[P5_W-1:0]);
  endproperty
  a_p5_write: assert property (p_p5_write)
    else $error("port five latch write lost");

  property p_p1_write;
    wr_i && sel_p1_latch |=> p1_latch_r == $past(wr_data_i);
  endproperty
  a_p1_write: assert property (p_p1_write)
    else $error("port one latch write lost");

  property p_dir_write;
    wr_i && sel_p1_dir |=> p1_dir_r == $past(wr_data_i);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("port one direction write lost");

  property p_input_undriven;
    (p1_pins_o.oe & ~$past(p1_dir_r)) == 8'h00;
  endproperty
  a_input_undriven: assert property (p_input_undriven)
    else $error("port one input-mode bit driven");

  property p_single_clock;
    !dual_clock_mode_i && pin_output_enable_i
      |=> p2_pins_o.oe[2:1] == ~$past(p2_latch_r[2:1]);
  endproperty
  a_single_clock: assert property (p_single_clock)
    else $error("port two bits 2-1 not a normal port in single-clock mode");

  property p_int_quiet;
    ext_int_o |-> $past(p2_in_i[0], 2) && !$past(p2_in_i[0]);
  endproperty
  a_int_quiet: assert property (p_int_quiet)
    else $error("interrupt pulse without a falling edge");

  property p_p3_latch;
    rd_i && sel_p3_latch |=> rd_data_o == $past(p3_latch_r);
  endproperty
  a_p3_latch: assert property (p_p3_latch)
    else $error("port three latch read wrong");

  property p_push_pull;
    pin_output_enable_i |=> (p4_pins_o.oe | ~$past(p4_drv_r)) == 8'hff;
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull bit of port four not driven");

  property p_pin_reg_ro;
    wr_i && sel_p4_pin |=> $stable(p4_latch_r) && $stable(p4_drv_r);
  endproperty
  a_pin_reg_ro: assert property (p_pin_reg_ro)
    else $error("write to port four pin register changed state");

  property p_p5_upper;
    rd_i && (sel_p5_latch || sel_p5_pin) |=> rd_data_o[7:5] == 3'h0;
  endproperty
  a_p5_upper: assert property (p_p5_upper)
    else $error("port five upper read bits not zero");

  property p_p5_pin;
    rd_i && sel_p5_pin |=> rd_data_o == {3'h0, $past(p5_in_i)};
  endproperty
  a_p5_pin: assert property (p_p5_pin)
    else $error("port five pin read wrong");
endmodule
`default_nettype wire

//--- verilog/mfio_pkg.sv
// shared constants and types for the multi-function port block
`default_nettype none
package mfio_pkg;
  localparam int ADDR_W = 8;
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_P1_LATCH = 8'h01;
  localparam logic [ADDR_W-1:0] OFF_P2_LATCH = 8'h02;
  localparam logic [ADDR_W-1:0] OFF_P3_LATCH = 8'h03;
  localparam logic [ADDR_W-1:0] OFF_P4_LATCH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_P5_LATCH = 8'h05;
  localparam logic [ADDR_W-1:0] OFF_P1_DIR   = 8'h09;
  localparam logic [ADDR_W-1:0] OFF_P4_DRV   = 8'h0a;
  localparam logic [ADDR_W-1:0] OFF_P4_PIN   = 8'h0e;
  localparam logic [ADDR_W-1:0] OFF_P2_PIN   = 8'h12;
  localparam logic [ADDR_W-1:0] OFF_P3_PIN   = 8'h13;
  localparam logic [ADDR_W-1:0] OFF_P5_PIN   = 8'h15;
  // port widths
  localparam int P2_W = 3;
  localparam int P5_W = 5;
  // reset values
  localparam logic [7:0]      RST_P1_LATCH = 8'h00;
  localparam logic [7:0]      RST_P1_DIR   = 8'h00;
  localparam logic [P2_W-1:0] RST_P2_LATCH = 3'h7;
  localparam logic [7:0]      RST_P3_LATCH = 8'hff;
  localparam logic [7:0]      RST_P4_LATCH = 8'hff;
  localparam logic [7:0]      RST_P4_DRV   = 8'h00;
  localparam logic [P5_W-1:0] RST_P5_LATCH = 5'h1f;
  // pin bundles: driven level and output enable
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } mfio_pin8_type;
  typedef struct packed {
    logic [P2_W-1:0] dout;
    logic [P2_W-1:0] oe;
  } mfio_pin3_type;
  typedef struct packed {
    logic [P5_W-1:0] dout;
    logic [P5_W-1:0] oe;
  } mfio_pin5_type;
endpackage
`default_nettype wire

//--- tb/mfio_pin_model.sv
// pad model: each pin follows the block where it drives, else the outside level
`default_nettype none
module mfio_pin_model (
  input  wire logic [7:0]              ext_i,
  input  wire mfio_pkg::mfio_pin8_type p1_i,
  input  wire mfio_pkg::mfio_pin3_type p2_i,
  input  wire mfio_pkg::mfio_pin8_type p3_i,
  input  wire mfio_pkg::mfio_pin8_type p4_i,
  input  wire mfio_pkg::mfio_pin5_type p5_i,
  output logic [7:0]                   p1_o,
  output logic [2:0]                   p2_o,
  output logic [7:0]                   p3_o,
  output logic [7:0]                   p4_o,
  output logic [4:0]                   p5_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign p1_o = (p1_i.oe & p1_i.dout) | (~p1_i.oe & ext_i);
  assign p2_o = (p2_i.oe & p2_i.dout) | (~p2_i.oe & ext_i[2:0]);
  assign p3_o = (p3_i.oe & p3_i.dout) | (~p3_i.oe & ext_i);
  assign p4_o = (p4_i.oe & p4_i.dout) | (~p4_i.oe & ext_i);
  assign p5_o = (p5_i.oe & p5_i.dout) | (~p5_i.oe & ext_i[4:0]);
endmodule
`default_nettype wire

//--- tb/mfio_ports_tb.sv
// self-checking bench for the multi-function port block
`default_nettype none
module mfio_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    sys_clk_i, resetn_i, wr, rd, pin_output_enable, stop, dual, ext_int;
  logic [7:0]              addr, wdata, ext, func, rdata, p1_in, p3_in, p4_in;
  logic [2:0]              p2_in;
  logic [4:0]              p5_in;
  mfio_pkg::mfio_pin8_type p1_pins, p3_pins, p4_pins;
  mfio_pkg::mfio_pin3_type p2_pins;
  mfio_pkg::mfio_pin5_type p5_pins;
  int                      miscompares, check_count, n;
  // rows: {write, address, write data or expected read}
  logic [16:0] rows [33] = '{17'h0015a, 17'h00900, 17'h00207, 17'h003ff, 17'h004ff,
    17'h00a00, 17'h0051f, 17'h01202, 17'h0135a, 17'h00e5a, 17'h0151a, 17'h101a5,
    17'h1090f, 17'h00155, 17'h10155, 17'h109ff, 17'h00155, 17'h10e00, 17'h004ff,
    17'h120ff, 17'h02000, 17'h1040f, 17'h10a0f, 17'h00e0f, 17'h10a00, 17'h00e0a,
    17'h0040f, 17'h1030f, 17'h0030f, 17'h0130a, 17'h10515, 17'h00515, 17'h01510};
  mfio_ports u_mfio_ports (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr),
    .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rdata),
    .pin_output_enable_i(pin_output_enable), .stop_mode_i(stop), .dual_clock_mode_i(dual),
    .p1_func_out_i(func), .p4_func_out_i(func), .p5_func_out_i(func[4:0]),
    .p1_in_i(p1_in), .p2_in_i(p2_in), .p3_in_i(p3_in), .p4_in_i(p4_in), .p5_in_i(p5_in),
    .p1_pins_o(p1_pins), .p2_pins_o(p2_pins), .p3_pins_o(p3_pins), .p4_pins_o(p4_pins),
    .p5_pins_o(p5_pins), .ext_int_o(ext_int));
  mfio_pin_model u_mfio_pin_model (.ext_i(ext), .p1_i(p1_pins), .p2_i(p2_pins),
    .p3_i(p3_pins), .p4_i(p4_pins), .p5_i(p5_pins), .p1_o(p1_in), .p2_o(p2_in),
    .p3_o(p3_in), .p4_o(p4_in), .p5_o(p5_in));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge sys_clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (!w)
      chk({8'h00, rdata}, {8'h00, d});
  endtask
  task automatic run_rows(input int hi);
    for (int i = 0; i < hi; i++)
      bus_op(rows[i][16], rows[i][15:8], rows[i][7:0]);
  endtask
  task automatic settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  initial
  begin
    {resetn_i, wr, rd, stop, dual, addr, wdata} = '0;
    {pin_output_enable, ext, func} = {1'b1, 8'h5a, 8'hff};
    miscompares = 0;
    check_count = 0;
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    run_rows(33);
    chk(p1_pins, 16'h55ff);
    chk(p3_pins, 16'h0ff0);
    chk(p4_pins, 16'h0ff0);
    chk({6'h00, p5_pins}, 16'h02aa);
    @(posedge sys_clk_i);
    func <= 8'h0f;
    pin_output_enable <= 1'b0;
    settle();
    chk(p1_pins, 16'h0500);
    @(posedge sys_clk_i);
    func <= 8'hff;
    pin_output_enable <= 1'b1;
    bus_op(1'b1, 8'h02, 8'h00);
    settle();
    chk({10'h000, p2_pins}, 16'h0007);
    @(posedge sys_clk_i);
    stop <= 1'b1;
    settle();
    chk({10'h000, p2_pins}, 16'h0006);
    @(posedge sys_clk_i);
    stop <= 1'b0;
    dual <= 1'b1;
    settle();
    chk({10'h000, p2_pins}, 16'h0001);
    @(posedge sys_clk_i);
    dual <= 1'b0;
    bus_op(1'b1, 8'h02, 8'h07);
    @(posedge sys_clk_i);
    ext <= 8'h5b;
    repeat (3) @(posedge sys_clk_i);
    ext <= 8'h5a;
    n = 0;
    while (ext_int !== 1'b1 && n < 6)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 6)
    begin
      miscompares++;
      tally_and_finish();
    end
    chk({15'h0000, ext_int}, 16'h0001);
    @(posedge sys_clk_i);
    #1;
    chk({15'h0000, ext_int}, 16'h0000);
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    settle();
    chk(p4_pins, 16'h0000);
    @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    run_rows(11);
    tally_and_finish();
  end
endmodule
`default_nettype wire
